/* File: rtl/dmp_ctrl.sv */
`timescale 1ns/1ps
module dmp_ctrl #(
   parameter logic [6:0] DEV_ADDR = dmp_pkg::DEV_ADDR_DEF,
   parameter int MUTE_CYC_96 = dmp_pkg::MUTE_CYC_96,
   parameter int MUTE_CYC_882 = dmp_pkg::MUTE_CYC_882
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Serial control pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Datapath status
   input wire logic [7:0] power_meter_in,
   input wire logic auto_mask_cond,
   input wire logic rate_882,
   input wire logic fault_n,
   // Compressor settings
   output logic all_pass_bypass,
   output logic two_band_select,
   output logic post_comp_type,
   output logic low_high_comp_type,
   output logic sub_comp_type,
   output logic clip_option,
   output logic [6:0] sub_band_threshold,
   output logic sub_band_comp_enable,
   output logic [3:0] sub_band_attack,
   output logic [2:0] sub_band_release,
   output logic sub_band_enable,
   output logic [4:0] threshold_map_coefficient,
   // Meter and volume
   output logic [1:0] meter_channel_select,
   output logic meter_tap_position,
   output logic [1:0] volume_ramp_rate,
   output logic [7:0] ch1_gain,
   output logic [7:0] ch2_gain,
   // Switching and mask
   output logic [1:0] channel_switching_stop,
   output logic mask_out,
   output logic outputs_off,
   output logic restore_counter_clear,
   output logic protect_req
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] scl_s_q, sda_s_q, flt_s_q;
   logic scl_f_q, scl_p_q, sda_f_q, sda_p_q, flt_f_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         flt_s_q <= 3'h7;
         scl_f_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_f_q <= 1'b1;
         sda_p_q <= 1'b1;
         flt_f_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_i};
         sda_s_q <= {sda_s_q[1:0], sda_i};
         flt_s_q <= {flt_s_q[1:0], fault_n};
         if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
         if (flt_s_q[1] == flt_s_q[2]) flt_f_q <= flt_s_q[2];
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
      end
   end
   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise = scl_f_q & ~scl_p_q;
   assign scl_fall = ~scl_f_q & scl_p_q;
   assign bus_start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
   assign bus_stop = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
   // ****************************************
   // Register storage
   // ****************************************
   logic [7:0] cmp_mode_q, sub_thr_q, sub_tim_q, sub_mode_q, coef_q;
   logic [7:0] pm_cfg_q, svol_q, smute_q, switch_q, mask_a_q, mask_b_q;
   function automatic logic [7:0] rd_val(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == dmp_pkg::ADR_CMP_MODE) v = cmp_mode_q;
      else if (a == dmp_pkg::ADR_SUB_THR) v = sub_thr_q;
      else if (a == dmp_pkg::ADR_SUB_TIM) v = sub_tim_q;
      else if (a == dmp_pkg::ADR_SUB_MODE) v = sub_mode_q;
      else if (a == dmp_pkg::ADR_COEF) v = coef_q;
      else if (a == dmp_pkg::ADR_PM_CFG) v = pm_cfg_q;
      else if (a == dmp_pkg::ADR_PM_VAL) v = power_meter_in;
      else if (a == dmp_pkg::ADR_SVOL) v = svol_q;
      else if (a == dmp_pkg::ADR_SMUTE) v = smute_q;
      else if (a == dmp_pkg::ADR_SWITCH) v = switch_q;
      else if (a == dmp_pkg::ADR_MASK_A) v = mask_a_q;
      else if (a == dmp_pkg::ADR_MASK_B) v = mask_b_q;
      return v;
   endfunction
   // ****************************************
   // Serial slave state machine
   // ****************************************
   dmp_pkg::dmp_state_t st_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, ptr_q, rd_byte;
   logic rw_q, nack_q, oe_q, wr_stb;
   always_comb rd_byte = rd_val(ptr_q);
   assign wr_stb = scl_fall && st_q == dmp_pkg::ST_WDATA && cnt_q == 4'h8;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_q <= dmp_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (bus_start) begin
         st_q <= dmp_pkg::ST_ADDR;
         cnt_q <= 4'h0;
         oe_q <= 1'b0;
      end else if (bus_stop) begin
         st_q <= dmp_pkg::ST_IDLE;
         oe_q <= 1'b0;
      end else if (scl_rise) begin
         case (st_q)
            dmp_pkg::ST_ADDR, dmp_pkg::ST_REG, dmp_pkg::ST_WDATA: begin
               sh_q <= {sh_q[6:0], sda_f_q};
               cnt_q <= 4'(cnt_q + 4'h1);
            end
            dmp_pkg::ST_RDATA: cnt_q <= 4'(cnt_q + 4'h1);
            dmp_pkg::ST_RACK: nack_q <= sda_f_q;
            default: ;
         endcase
      end else if (scl_fall) begin
         case (st_q)
            dmp_pkg::ST_ADDR: if (cnt_q == 4'h8) begin
               cnt_q <= 4'h0;
               if (sh_q[7:1] == DEV_ADDR) begin
                  oe_q <= 1'b1;
                  rw_q <= sh_q[0];
                  st_q <= dmp_pkg::ST_ACK_A;
               end else begin
                  st_q <= dmp_pkg::ST_IDLE;
               end
            end
            dmp_pkg::ST_ACK_A: if (rw_q) begin
               sh_q <= rd_byte;
               oe_q <= ~rd_byte[7];
               st_q <= dmp_pkg::ST_RDATA;
            end else begin
               oe_q <= 1'b0;
               st_q <= dmp_pkg::ST_REG;
            end
            dmp_pkg::ST_REG: if (cnt_q == 4'h8) begin
               cnt_q <= 4'h0;
               ptr_q <= sh_q;
               oe_q <= 1'b1;
               st_q <= dmp_pkg::ST_ACK_R;
            end
            dmp_pkg::ST_ACK_R, dmp_pkg::ST_ACK_D: begin
               oe_q <= 1'b0;
               st_q <= dmp_pkg::ST_WDATA;
            end
            dmp_pkg::ST_WDATA: if (cnt_q == 4'h8) begin
               cnt_q <= 4'h0;
               ptr_q <= 8'(ptr_q + 8'h01);
               oe_q <= 1'b1;
               st_q <= dmp_pkg::ST_ACK_D;
            end
            dmp_pkg::ST_RDATA: if (cnt_q == 4'h8) begin
               cnt_q <= 4'h0;
               ptr_q <= 8'(ptr_q + 8'h01);
               oe_q <= 1'b0;
               st_q <= dmp_pkg::ST_RACK;
            end else begin
               sh_q <= {sh_q[6:0], 1'b0};
               oe_q <= ~sh_q[6];
            end
            dmp_pkg::ST_RACK: if (nack_q) begin
               st_q <= dmp_pkg::ST_IDLE;
            end else begin
               sh_q <= rd_byte;
               oe_q <= ~rd_byte[7];
               st_q <= dmp_pkg::ST_RDATA;
            end
            default: ;
         endcase
      end
   end
   // Open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe = oe_q;
   // ****************************************
   // Compressor registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cmp_mode_q <= dmp_pkg::RST_ZERO;
         sub_thr_q <= dmp_pkg::RST_SUB_THR;
         sub_tim_q <= dmp_pkg::RST_SUB_TIM;
         sub_mode_q <= dmp_pkg::RST_ZERO;
         coef_q <= dmp_pkg::RST_COEF;
      end else if (wr_stb) begin
         if (ptr_q == dmp_pkg::ADR_CMP_MODE) begin
            cmp_mode_q <= sh_q & dmp_pkg::WM_CMP_MODE;
         end else if (ptr_q == dmp_pkg::ADR_SUB_THR) begin
            sub_thr_q <= sh_q & dmp_pkg::WM_SUB_THR;
         end else if (ptr_q == dmp_pkg::ADR_SUB_TIM) begin
            // Out of range attack codes saturate rather than alias
            sub_tim_q[6:4] <= sh_q[6:4];
            sub_tim_q[3:0] <= (sh_q[3:0] > dmp_pkg::ATTACK_MAX) ?
               dmp_pkg::ATTACK_MAX : sh_q[3:0];
         end else if (ptr_q == dmp_pkg::ADR_SUB_MODE) begin
            sub_mode_q <= sh_q & dmp_pkg::WM_SUB_MODE;
         end else if (ptr_q == dmp_pkg::ADR_COEF) begin
            coef_q <= (sh_q[4:0] > dmp_pkg::COEF_MAX) ?
               {3'h0, dmp_pkg::COEF_MAX} : (sh_q & dmp_pkg::WM_COEF);
         end
      end
   end
   assign all_pass_bypass = cmp_mode_q[dmp_pkg::BIT_ALLPASS];
   assign two_band_select = cmp_mode_q[dmp_pkg::BIT_TWO_BAND];
   assign post_comp_type = cmp_mode_q[dmp_pkg::BIT_POST_TYPE];
   assign low_high_comp_type = cmp_mode_q[dmp_pkg::BIT_LH_TYPE];
   assign sub_comp_type = sub_mode_q[dmp_pkg::BIT_SUB_TYPE];
   assign clip_option = cmp_mode_q[dmp_pkg::BIT_CLIP];
   assign sub_band_threshold = sub_thr_q[6:0];
   assign sub_band_comp_enable = sub_thr_q[dmp_pkg::BIT_SUB_COMP_EN];
   assign sub_band_attack = sub_tim_q[3:0];
   assign sub_band_release = sub_tim_q[6:4];
   assign sub_band_enable = sub_mode_q[dmp_pkg::BIT_SUB_ENABLE];
   assign threshold_map_coefficient = coef_q[4:0];
   // ****************************************
   // Meter, volume, mute and switching registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pm_cfg_q <= dmp_pkg::RST_ZERO;
         svol_q <= dmp_pkg::RST_ZERO;
         smute_q <= dmp_pkg::RST_ZERO;
         switch_q <= dmp_pkg::RST_ZERO;
      end else if (wr_stb) begin
         // Meter value address is absent here, so its writes drop
         if (ptr_q == dmp_pkg::ADR_PM_CFG) begin
            pm_cfg_q <= sh_q & dmp_pkg::WM_PM_CFG;
         end else if (ptr_q == dmp_pkg::ADR_SVOL) begin
            svol_q <= sh_q & dmp_pkg::WM_SVOL;
         end else if (ptr_q == dmp_pkg::ADR_SMUTE) begin
            smute_q <= sh_q & dmp_pkg::WM_SMUTE;
         end else if (ptr_q == dmp_pkg::ADR_SWITCH) begin
            switch_q <= sh_q & dmp_pkg::WM_SWITCH;
         end
      end
   end
   assign meter_channel_select = pm_cfg_q[1:0];
   assign meter_tap_position = pm_cfg_q[dmp_pkg::BIT_METER_POS];
   assign volume_ramp_rate = svol_q[1:0];
   assign channel_switching_stop = switch_q[1:0];
   // ****************************************
   // Soft mute gain ramp
   // ****************************************
   localparam int STEP_96 = (MUTE_CYC_96 / dmp_pkg::GAIN_STEPS < 1) ? 1 :
      MUTE_CYC_96 / dmp_pkg::GAIN_STEPS;
   localparam int STEP_882 = (MUTE_CYC_882 / dmp_pkg::GAIN_STEPS < 1) ? 1 :
      MUTE_CYC_882 / dmp_pkg::GAIN_STEPS;
   logic [31:0] div_q, step_lim;
   logic [7:0] gain_q [2];
   logic tick, hard_mute;
   assign step_lim = rate_882 ? 32'(STEP_882 - 1) : 32'(STEP_96 - 1);
   assign tick = div_q >= step_lim;
   assign hard_mute = smute_q[dmp_pkg::BIT_MUTE_SPEED];
   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_q <= 32'h0000_0000;
      end else if (tick) begin
         div_q <= 32'h0000_0000;
      end else begin
         div_q <= 32'(div_q + 32'h0000_0001);
      end
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         gain_q[0] <= dmp_pkg::GAIN_FULL;
         gain_q[1] <= dmp_pkg::GAIN_FULL;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (hard_mute) begin
               gain_q[i] <= smute_q[i] ? dmp_pkg::GAIN_ZERO : dmp_pkg::GAIN_FULL;
            end else if (tick) begin
               // One step per tick spreads a full swing over the mute time
               if (smute_q[i] && gain_q[i] != dmp_pkg::GAIN_ZERO) begin
                  gain_q[i] <= 8'(gain_q[i] - 8'h01);
               end else if (!smute_q[i] && gain_q[i] != dmp_pkg::GAIN_FULL) begin
                  gain_q[i] <= 8'(gain_q[i] + 8'h01);
               end
            end
         end
      end
   end
   assign ch1_gain = gain_q[0];
   assign ch2_gain = gain_q[1];
   // ****************************************
   // Output mask and protection
   // ****************************************
   logic mask_q, off_q, clr_q, prot_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         mask_a_q <= dmp_pkg::RST_ZERO;
         mask_b_q <= dmp_pkg::RST_ZERO;
      end else if (wr_stb) begin
         if (ptr_q == dmp_pkg::ADR_MASK_A) begin
            mask_a_q <= sh_q & dmp_pkg::WM_MASK_A;
         end else if (ptr_q == dmp_pkg::ADR_MASK_B) begin
            mask_b_q <= sh_q & dmp_pkg::WM_MASK_B;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         mask_q <= 1'b1;
         off_q <= 1'b0;
         clr_q <= 1'b0;
         prot_q <= 1'b0;
      end else begin
         mask_q <= !(mask_a_q[1:0] == dmp_pkg::MASK_FORCE_LOW ||
            (mask_b_q[dmp_pkg::BIT_AUTO_MASK] && auto_mask_cond));
         off_q <= mask_b_q[dmp_pkg::BIT_AUTO_OFF] && auto_mask_cond;
         clr_q <= wr_stb && ptr_q == dmp_pkg::ADR_MASK_A &&
            sh_q[dmp_pkg::BIT_RST_CLR];
         prot_q <= !flt_f_q && !mask_a_q[dmp_pkg::BIT_FAULT_IGN];
      end
   end
   assign mask_out = mask_q;
   assign outputs_off = off_q;
   assign restore_counter_clear = clr_q;
   assign protect_req = prot_q;
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   AST_MASK_FORCE: assert property (
      mask_a_q[1:0] == 2'b10 |=> !mask_out) else $error("mask not forced low");
   AST_MASK_HIGH: assert property (
      mask_a_q[1:0] != 2'b10 && !(mask_b_q[1] && auto_mask_cond) |=> mask_out)
      else $error("mask low without cause");
   AST_MASK_AUTO: assert property (
      mask_b_q[1] && auto_mask_cond |=> !mask_out) else $error("auto mask ignored");
   AST_OFF_FLAG: assert property (
      !mask_b_q[0] |=> !outputs_off) else $error("outputs off without flag");
   AST_CLR_PULSE: assert property (
      wr_stb && ptr_q == 8'h35 |=> restore_counter_clear == $past(sh_q[2]))
      else $error("restore clear mismatch");
   AST_FAULT_IGN: assert property (
      mask_a_q[3] |=> !protect_req) else $error("ignored fault protected");
   AST_PM_RO: assert property (
      ptr_q == 8'h2F |-> rd_byte == power_meter_in) else $error("meter readback");
   AST_HARD_MUTE: assert property (
      smute_q[7] && smute_q[0] |=> ch1_gain == 8'h00) else $error("hard mute slow");
   AST_ATTACK_MAX: assert property (
      sub_band_attack <= 4'hA) else $error("attack out of range");
   AST_COEF_MAX: assert property (
      threshold_map_coefficient <= 5'd20) else $error("coefficient out of range");
   COV_WRITE: cover property (wr_stb ##[1:300] st_q == dmp_pkg::ST_ACK_D);
   COV_READ: cover property (st_q == dmp_pkg::ST_RDATA && cnt_q == 4'h8);
   COV_RAMP: cover property (!smute_q[7] && smute_q[0] && ch1_gain == 8'h00);
endmodule

/* File: rtl/dmp_pkg.sv */
package dmp_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADR_CMP_MODE = 8'h29;
   localparam logic [7:0] ADR_SUB_THR = 8'h2A;
   localparam logic [7:0] ADR_SUB_TIM = 8'h2B;
   localparam logic [7:0] ADR_SUB_MODE = 8'h2C;
   localparam logic [7:0] ADR_COEF = 8'h2D;
   localparam logic [7:0] ADR_PM_CFG = 8'h2E;
   localparam logic [7:0] ADR_PM_VAL = 8'h2F;
   localparam logic [7:0] ADR_SVOL = 8'h30;
   localparam logic [7:0] ADR_SMUTE = 8'h33;
   localparam logic [7:0] ADR_SWITCH = 8'h34;
   localparam logic [7:0] ADR_MASK_A = 8'h35;
   localparam logic [7:0] ADR_MASK_B = 8'h36;

   // ****************************************
   // Writable bits and reset values
   // ****************************************
   localparam logic [7:0] WM_CMP_MODE = 8'hF1;
   localparam logic [7:0] WM_SUB_THR = 8'hFF;
   localparam logic [7:0] WM_SUB_TIM = 8'h7F;
   localparam logic [7:0] WM_SUB_MODE = 8'h03;
   localparam logic [7:0] WM_COEF = 8'h1F;
   localparam logic [7:0] WM_PM_CFG = 8'h13;
   localparam logic [7:0] WM_SVOL = 8'h03;
   localparam logic [7:0] WM_SMUTE = 8'h83;
   localparam logic [7:0] WM_SWITCH = 8'h03;
   localparam logic [7:0] WM_MASK_A = 8'h0B;
   localparam logic [7:0] WM_MASK_B = 8'h03;
   localparam logic [7:0] RST_SUB_THR = 8'h6A;
   localparam logic [7:0] RST_SUB_TIM = 8'h01;
   localparam logic [7:0] RST_COEF = 8'h0A;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // ****************************************
   // Field positions and codes
   // ****************************************
   localparam int BIT_ALLPASS = 0;
   localparam int BIT_TWO_BAND = 4;
   localparam int BIT_POST_TYPE = 5;
   localparam int BIT_LH_TYPE = 6;
   localparam int BIT_CLIP = 7;
   localparam int BIT_SUB_COMP_EN = 7;
   localparam int BIT_SUB_ENABLE = 0;
   localparam int BIT_SUB_TYPE = 1;
   localparam int BIT_METER_POS = 4;
   localparam int BIT_MUTE_SPEED = 7;
   localparam int BIT_FAULT_IGN = 3;
   localparam int BIT_RST_CLR = 2;
   localparam int BIT_AUTO_OFF = 0;
   localparam int BIT_AUTO_MASK = 1;
   localparam logic [1:0] MASK_FORCE_LOW = 2'b10;
   localparam logic [3:0] ATTACK_MAX = 4'hA;
   localparam logic [4:0] COEF_MAX = 5'h14;
   localparam logic [7:0] GAIN_FULL = 8'hFF;
   localparam logic [7:0] GAIN_ZERO = 8'h00;
   localparam int GAIN_STEPS = 255;
   localparam logic [6:0] DEV_ADDR_DEF = 7'h2A; // Arbitrary bus address

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 125;
   localparam int MUTE_US_96 = 42000;
   localparam int MUTE_US_882 = 46000;
   localparam int MUTE_CYC_96 = MUTE_US_96 * CLK_MHZ;
   localparam int MUTE_CYC_882 = MUTE_US_882 * CLK_MHZ;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_A, ST_REG, ST_ACK_R,
      ST_WDATA, ST_ACK_D, ST_RDATA, ST_RACK
   } dmp_state_t;

endpackage

/* File: tb/dmp_host.sv */
`timescale 1ns/1ps
module dmp_host #(
   parameter logic [6:0] DEV = 7'h2A
) (
   // Clock
   input wire logic clock,
   // Bus lines, data is pulled up
   input wire logic sda_in,
   output logic scl,
   output logic sda_low
);
   // Half period twice the minimum, data moves a third into low phase
   localparam int H = 16;
   int nack_cnt = 0;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic bit_io(input logic b, output logic r);
      hc(H / 2);
      sda_low = ~b;
      hc(H);
      scl = 1'b1;
      hc(H);
      r = sda_in;
      scl = 1'b0;
   endtask
   task automatic start();
      hc(H / 2);
      sda_low = 1'b0;
      hc(H);
      scl = 1'b1;
      hc(H);
      sda_low = 1'b1;
      hc(H);
      scl = 1'b0;
   endtask
   task automatic stop();
      hc(H / 2);
      sda_low = 1'b1;
      hc(H);
      scl = 1'b1;
      hc(H);
      sda_low = 1'b0;
      hc(H);
   endtask
   task automatic put(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      if (r !== 1'b0) nack_cnt++;
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d, int n);
      start();
      put({dev, 1'b0});
      put(ra);
      repeat (n) put(d);
      stop();
   endtask
   task automatic rd(input logic [7:0] ra, input int n, output logic [7:0] q[$]);
      logic [7:0] v;
      logic r;
      q = {};
      start();
      put({DEV, 1'b0});
      put(ra);
      start();
      put({DEV, 1'b1});
      for (int i = 0; i < n; i++) begin
         for (int b = 7; b >= 0; b--) begin
            bit_io(1'b1, r);
            v[b] = r;
         end
         bit_io(i == n - 1, r);
         q.push_back(v);
      end
      stop();
   endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   // ****************
   // Signals
   // ****************
   localparam logic [6:0] DEV = 7'h2A; // Arbitrary value
   logic clock, nrst, scl, sda_low, sda, sda_o, sda_oe;
   logic [7:0] power_meter_in, ch1_gain, ch2_gain;
   logic auto_mask_cond, rate_882, fault_n, all_pass_bypass, two_band_select;
   logic post_comp_type, low_high_comp_type, sub_comp_type, clip_option;
   logic [6:0] sub_band_threshold;
   logic sub_band_comp_enable, sub_band_enable, meter_tap_position;
   logic [3:0] sub_band_attack;
   logic [2:0] sub_band_release;
   logic [4:0] threshold_map_coefficient;
   logic [1:0] meter_channel_select, volume_ramp_rate, channel_switching_stop;
   logic mask_out, outputs_off, restore_counter_clear, protect_req;
   int bad_count = 0;
   int cmp_count = 0;
   int clr_cnt = 0;
   assign sda = ~(sda_low | (sda_oe & ~sda_o));
   dmp_ctrl #(.DEV_ADDR(DEV), .MUTE_CYC_96(510), .MUTE_CYC_882(765)) u_dmp_ctrl (
      .clock, .nrst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .power_meter_in,
      .auto_mask_cond, .rate_882, .fault_n, .all_pass_bypass, .two_band_select,
      .post_comp_type, .low_high_comp_type, .sub_comp_type, .clip_option,
      .sub_band_threshold, .sub_band_comp_enable, .sub_band_attack, .sub_band_release,
      .sub_band_enable, .threshold_map_coefficient, .meter_channel_select,
      .meter_tap_position, .volume_ramp_rate, .ch1_gain, .ch2_gain,
      .channel_switching_stop, .mask_out, .outputs_off, .restore_counter_clear,
      .protect_req);
   dmp_host #(.DEV(DEV)) u_dmp_host (.clock, .sda_in(sda), .scl, .sda_low);
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      if (restore_counter_clear === 1'b1) clr_cnt++;
   end
   // ****************
   // Checks
   // ****************
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Readback of 0x29 to 0x36, gaps and reserved bits read zero
   task automatic regs(input logic [7:0] e[14]);
      logic [7:0] q[$];
      u_dmp_host.rd(8'h29, 14, q);
      foreach (e[i]) chk($sformatf("reg %h", 8'h29 + i), q[i], (i == 6) ? power_meter_in : e[i]);
   endtask
   task automatic outs(input logic [7:0] e[8]);
      chk("mode", {clip_option, low_high_comp_type, post_comp_type, two_band_select,
         3'b000, all_pass_bypass}, e[0]);
      chk("thr", {sub_band_comp_enable, sub_band_threshold}, e[1]);
      chk("tim", {1'b0, sub_band_release, sub_band_attack}, e[2]);
      chk("sub", {6'h00, sub_comp_type, sub_band_enable}, e[3]);
      chk("coef", {3'h0, threshold_map_coefficient}, e[4]);
      chk("meter", {3'h0, meter_tap_position, 2'b00, meter_channel_select}, e[5]);
      chk("vol", {6'h00, volume_ramp_rate}, e[6]);
      chk("sw", {6'h00, channel_switching_stop}, e[7]);
   endtask
   // ****************
   // Tests
   // ****************
   initial begin
      nrst = 1'b0;
      power_meter_in = 8'h5C;
      auto_mask_cond = 1'b0;
      rate_882 = 1'b0;
      fault_n = 1'b1;
      step(20);
      nrst = 1'b1;
      step(4);
      regs('{8'h00, 8'h6A, 8'h01, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
         8'h00, 8'h00, 8'h00, 8'h00});
      outs('{8'h00, 8'h6A, 8'h01, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h00});
      chk("gain", ch1_gain, 8'hFF);
      chk("mask", mask_out, 8'h01);
      // All ones burst: clamps, write-only clear, read-only meter
      u_dmp_host.wr(DEV, 8'h29, 8'hFF, 14);
      power_meter_in = 8'hC3;
      regs('{8'hF1, 8'hFF, 8'h7A, 8'h03, 8'h14, 8'h13, 8'h00, 8'h03, 8'h00, 8'h00,
         8'h83, 8'h03, 8'h0B, 8'h03});
      outs('{8'hF1, 8'hFF, 8'h7A, 8'h03, 8'h14, 8'h13, 8'h03, 8'h03});
      chk("hard mute", {ch1_gain | ch2_gain}, 8'h00);
      chk("clear", 8'(clr_cnt), 8'h01);
      // Wrong device address is not answered and changes nothing
      u_dmp_host.wr(7'h2B, 8'h29, 8'h00, 1);
      chk("nack", 8'(u_dmp_host.nack_cnt), 8'h03);
      outs('{8'hF1, 8'hFF, 8'h7A, 8'h03, 8'h14, 8'h13, 8'h03, 8'h03});
      u_dmp_host.wr(DEV, 8'h29, 8'h00, 14);
      outs('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      // Soft mute at both rates; long counts shortened by parameter
      u_dmp_host.wr(DEV, 8'h33, 8'h03, 1);
      chk("ramp mid", 8'(ch1_gain != 8'h00 && ch1_gain != 8'hFF), 8'h01);
      step(600);
      chk("ramp down", {ch1_gain | ch2_gain}, 8'h00);
      rate_882 = 1'b1;
      u_dmp_host.wr(DEV, 8'h33, 8'h00, 1);
      step(500);
      chk("slow ramp", 8'(ch2_gain != 8'hFF), 8'h01);
      step(400);
      chk("ramp up", {ch1_gain & ch2_gain}, 8'hFF);
      u_dmp_host.wr(DEV, 8'h33, 8'h81, 1);
      chk("hard ch", {ch1_gain[0], ch2_gain[0]}, 8'h01);
      for (int c = 0; c < 4; c++) begin
         u_dmp_host.wr(DEV, 8'h2E, 8'(c), 1);
         u_dmp_host.wr(DEV, 8'h30, 8'(c), 1);
         u_dmp_host.wr(DEV, 8'h35, 8'(c), 1);
         chk("meter ch", {6'h00, meter_channel_select}, 8'(c));
         chk("vol rate", {6'h00, volume_ramp_rate}, 8'(c));
         chk("mask code", mask_out, 8'(c != 2));
      end
      // Automatic mask condition with and without flags
      u_dmp_host.wr(DEV, 8'h36, 8'h03, 1);
      auto_mask_cond = 1'b1;
      step(2);
      chk("auto mask", {mask_out, outputs_off}, 8'h01);
      u_dmp_host.wr(DEV, 8'h36, 8'h00, 1);
      chk("no auto", {mask_out, outputs_off}, 8'h02);
      auto_mask_cond = 1'b0;
      fault_n = 1'b0;
      step(8);
      chk("fault", protect_req, 8'h01);
      u_dmp_host.wr(DEV, 8'h35, 8'h08, 1);
      chk("fault off", protect_req, 8'h00);
      chk("clear", 8'(clr_cnt), 8'h01);
      chk("nack", 8'(u_dmp_host.nack_cnt), 8'h03);
      test_done();
   end
   // Whole run is about 49k cycles
   initial begin
      repeat (100000) @(posedge clock);
      bad_count++;
      test_done();
   end
endmodule
